// >>> evt_flag_pkg.sv
// Shared constants and types for the event flag unit and its servicing host.
// Notes on behaviour
// - Two active-low request lines, each with words.
// - Enable bit one passes event, zero blocks.
// - Events set flags whatever enable holds; sticky.
// - Line low while any enabled flag set.
// - Writing one clears a flag; zero keeps.
// - Line stays low until enabled flags cleared.
// - All enables zero after reset.
// - Reset-finished ignores its enable bit.
// - Every reset end sets reset-finished flag.
// - Second word bits 0-2 are idle-load events.
// - Second word bits 16-18 are condition events.
// - Second word bits 23-24 are peak events.
// - First word sign bits have phase detail.
// - Host reads companion before clearing its flag.
// - Host reads flags, writes same value back.
// - Host detects request on falling edge.
// - Host clears its latch entering service.
// - Phase detail updates with its own event flag.
package evt_flag_pkg;

  localparam int WORD_W = 32;
  localparam int ADDR_W = 4;
  localparam int COMP_N = 5;
  localparam int CIDX_W = 3;

  // Device register indices on the link.
  localparam logic [ADDR_W-1:0] REG_EN_FIRST = 4'h0;
  localparam logic [ADDR_W-1:0] REG_EN_SECOND = 4'h1;
  localparam logic [ADDR_W-1:0] REG_FL_FIRST = 4'h2;
  localparam logic [ADDR_W-1:0] REG_FL_SECOND = 4'h3;
  localparam logic [ADDR_W-1:0] REG_COMP_BASE = 4'h4;

  localparam int RST_DONE_BIT = 15;
  localparam logic [WORD_W-1:0] RST_DONE_MASK = 32'h0000_8000;

  // Companion order: idle load, condition, current peak, voltage peak,
  // power sign.
  localparam logic [COMP_N-1:0][WORD_W-1:0] COMP_MASK = {
    32'h0004_3fc0,
    32'h0100_0000,
    32'h0080_0000,
    32'h0007_0000,
    32'h0000_0007
  };
  // A one marks a companion that belongs to the first flag word.
  localparam logic [COMP_N-1:0] COMP_OF_FIRST = 5'h10;

  // Host software registers.
  localparam logic [ADDR_W-1:0] HREG_STATUS = 4'h0;
  localparam logic [ADDR_W-1:0] HREG_CLEAR = 4'h1;
  localparam logic [ADDR_W-1:0] HREG_ENABLE = 4'h2;
  localparam logic [ADDR_W-1:0] HREG_SNAP_FIRST = 4'h3;
  localparam logic [ADDR_W-1:0] HREG_SNAP_SECOND = 4'h4;
  localparam logic [ADDR_W-1:0] HREG_COMP_BASE = 4'h5;
  localparam logic [ADDR_W-1:0] HREG_DEV_EN_FIRST = 4'ha;
  localparam logic [ADDR_W-1:0] HREG_DEV_EN_SECOND = 4'hb;

  localparam int HST_W = 3;
  localparam int HST_FIRST_DONE = 0;
  localparam int HST_SECOND_DONE = 1;
  localparam int HST_RST_SEEN = 2;

  typedef enum logic [1:0] {
    SVC_IDLE = 2'h0,
    SVC_WAIT = 2'h1,
    SVC_CAPTURE = 2'h3,
    SVC_SCAN = 2'h2
  } svc_state_e;

endpackage

// >>> evt_link_if.sv
// Link between the event flag unit and the host that services it.
`timescale 1ns/100ps
interface evt_link_if;
  logic [evt_flag_pkg::ADDR_W-1:0] addr;
  logic [evt_flag_pkg::WORD_W-1:0] wdata;
  logic [evt_flag_pkg::WORD_W-1:0] rdata;
  logic wr;
  logic rd;
  logic request_line_first_n;
  logic request_line_second_n;

  modport dev (
    input addr,
    input wdata,
    input wr,
    input rd,
    output rdata,
    output request_line_first_n,
    output request_line_second_n
  );

  modport host (
    output addr,
    output wdata,
    output wr,
    output rd,
    input rdata,
    input request_line_first_n,
    input request_line_second_n
  );
endinterface

// >>> evt_flag_dev.sv
// Event flag unit: two flag words, two enable words, two request lines.
`timescale 1ns/100ps
module evt_flag_dev (
  input wire logic CORE_CLK_I,
  input wire logic NRST_I,
  input wire logic SOFT_RESET_I,
  input wire logic [evt_flag_pkg::WORD_W-1:0] EVT_FIRST_I,
  input wire logic [evt_flag_pkg::WORD_W-1:0] EVT_SECOND_I,
  input wire logic [evt_flag_pkg::COMP_N-1:0][evt_flag_pkg::WORD_W-1:0]
    PHASE_DETAIL_I,
  evt_link_if.dev LINK
);

  typedef struct packed {
    logic [evt_flag_pkg::WORD_W-1:0] en_first;
    logic [evt_flag_pkg::WORD_W-1:0] en_second;
    logic [evt_flag_pkg::WORD_W-1:0] fl_first;
    logic [evt_flag_pkg::WORD_W-1:0] fl_second;
    logic [evt_flag_pkg::COMP_N-1:0][evt_flag_pkg::WORD_W-1:0] comp;
    logic [evt_flag_pkg::WORD_W-1:0] rdata;
    logic boot;
    logic req_first_n;
    logic req_second_n;
  } dev_state_s;

  dev_state_s q;
  dev_state_s d;

  logic [evt_flag_pkg::WORD_W-1:0] clr_first;
  logic [evt_flag_pkg::WORD_W-1:0] clr_second;
  logic [evt_flag_pkg::WORD_W-1:0] ev_second;
  logic [evt_flag_pkg::WORD_W-1:0] en_second_eff;
  logic [evt_flag_pkg::WORD_W-1:0] src;
  logic [evt_flag_pkg::ADDR_W-1:0] comp_addr;

  always_comb begin
    d = q;
    src = '0;
    comp_addr = '0;

    // Write-one-to-clear masks; a zero bit leaves its flag alone.
    clr_first = '0;
    clr_second = '0;
    if (LINK.wr && LINK.addr == evt_flag_pkg::REG_FL_FIRST) begin
      clr_first = LINK.wdata;
    end
    if (LINK.wr && LINK.addr == evt_flag_pkg::REG_FL_SECOND) begin
      clr_second = LINK.wdata;
    end

    if (LINK.wr && LINK.addr == evt_flag_pkg::REG_EN_FIRST) begin
      d.en_first = LINK.wdata;
    end
    if (LINK.wr && LINK.addr == evt_flag_pkg::REG_EN_SECOND) begin
      d.en_second = LINK.wdata;
    end

    // The flag of reset completion rises one cycle after any reset ends.
    ev_second = EVT_SECOND_I;
    if (q.boot) begin
      ev_second[evt_flag_pkg::RST_DONE_BIT] = 1'b1;
    end
    d.boot = 1'b0;

    // Clear first, then set, so an event in the clearing cycle survives.
    d.fl_first = (q.fl_first & ~clr_first) | EVT_FIRST_I;
    d.fl_second = (q.fl_second & ~clr_second) | ev_second;

    // Companion detail is captured in the cycle its flag is set, so the
    // host sees the phase that caused the most recent event.
    for (int k = 0; k < evt_flag_pkg::COMP_N; k++) begin
      if (evt_flag_pkg::COMP_OF_FIRST[k]) begin
        src = EVT_FIRST_I;
      end else begin
        src = ev_second;
      end
      if (|(src & evt_flag_pkg::COMP_MASK[k])) begin
        d.comp[k] = PHASE_DETAIL_I[k];
      end
    end

    // Read data stand in the cycle after the strobe only.
    d.rdata = '0;
    if (LINK.rd) begin
      unique case (LINK.addr)
        evt_flag_pkg::REG_EN_FIRST: begin
          d.rdata = q.en_first;
        end
        evt_flag_pkg::REG_EN_SECOND: begin
          d.rdata = q.en_second;
        end
        evt_flag_pkg::REG_FL_FIRST: begin
          d.rdata = q.fl_first;
        end
        evt_flag_pkg::REG_FL_SECOND: begin
          d.rdata = q.fl_second;
        end
        default: begin
          comp_addr = LINK.addr - evt_flag_pkg::REG_COMP_BASE;
          if (LINK.addr >= evt_flag_pkg::REG_COMP_BASE &&
              comp_addr < evt_flag_pkg::ADDR_W'(evt_flag_pkg::COMP_N)) begin
            d.rdata = q.comp[comp_addr[evt_flag_pkg::CIDX_W-1:0]];
          end
        end
      endcase
    end

    // A software reset returns enables, flags and companions to their reset state and then
    // raises the completion flag like any other reset.
    if (SOFT_RESET_I) begin
      d.en_first = '0;
      d.en_second = '0;
      d.fl_first = '0;
      d.fl_second = '0;
      d.comp = '0;
      d.boot = 1'b1;
    end

    // The completion event cannot be masked, so its enable bit is stored
    // for read-back but never looked at.
    en_second_eff = d.en_second | evt_flag_pkg::RST_DONE_MASK;

    // Lines follow the next state so that they move with their flags and
    // release only once every enabled flag is gone.
    d.req_first_n = ~|(d.fl_first & d.en_first);
    d.req_second_n = ~|(d.fl_second & en_second_eff);
  end

  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      q <= '0;
      q.boot <= 1'b1;
      q.req_first_n <= 1'b1;
      q.req_second_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign LINK.rdata = q.rdata;
  assign LINK.request_line_first_n = q.req_first_n;
  assign LINK.request_line_second_n = q.req_second_n;

endmodule // evt_flag_dev

// >>> evt_flag_host.sv
// Host that services both request lines and reports to its own software.
//
// Chosen here: the address map and the strobed register port.
`timescale 1ns/100ps
module evt_flag_host (
  input wire logic CORE_CLK_I,
  input wire logic NRST_I,
  input wire logic [evt_flag_pkg::ADDR_W-1:0] ADDR_I,
  input wire logic [evt_flag_pkg::WORD_W-1:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [evt_flag_pkg::WORD_W-1:0] RDATA_O,
  output logic IRQ_O,
  evt_link_if.host LINK
);

  typedef struct packed {
    evt_flag_pkg::svc_state_e state;
    logic [1:0] prev_n;
    logic [1:0] latch;
    logic line;
    logic rd_comp;
    logic [evt_flag_pkg::CIDX_W-1:0] cidx;
    logic [1:0][evt_flag_pkg::WORD_W-1:0] snap;
    logic [evt_flag_pkg::COMP_N-1:0][evt_flag_pkg::WORD_W-1:0] comp;
    logic [evt_flag_pkg::HST_W-1:0] status;
    logic [evt_flag_pkg::HST_W-1:0] enable;
    logic [1:0] pend;
    logic [1:0][evt_flag_pkg::WORD_W-1:0] pend_val;
    logic [evt_flag_pkg::ADDR_W-1:0] addr;
    logic [evt_flag_pkg::WORD_W-1:0] wdata;
    logic wr;
    logic rd;
    logic [evt_flag_pkg::WORD_W-1:0] rdata;
    logic irq;
  } host_state_s;

  host_state_s q;
  host_state_s d;
  logic [1:0] now_n;
  logic [evt_flag_pkg::WORD_W-1:0] need_src;
  logic [evt_flag_pkg::HST_W-1:0] ev;
  logic [evt_flag_pkg::ADDR_W-1:0] sw_comp;

  always_comb begin
    d = q;
    d.wr = 1'b0;
    d.rd = 1'b0;
    ev = '0;
    need_src = '0;
    sw_comp = ADDR_I - evt_flag_pkg::HREG_COMP_BASE;
    now_n = {LINK.request_line_second_n, LINK.request_line_first_n};
    d.prev_n = now_n;

    unique case (q.state)
      evt_flag_pkg::SVC_IDLE: begin
        if (q.pend[0]) begin
          d.pend[0] = 1'b0;
          d.wr = 1'b1;
          d.addr = evt_flag_pkg::REG_EN_FIRST;
          d.wdata = q.pend_val[0];
        end else if (q.pend[1]) begin
          d.pend[1] = 1'b0;
          d.wr = 1'b1;
          d.addr = evt_flag_pkg::REG_EN_SECOND;
          d.wdata = q.pend_val[1];
        end else if (q.latch != 2'h0) begin
          // The latch is dropped on entry; a new edge during service
          // sets it again and is serviced after return.
          d.line = q.latch[1];
          d.latch[q.latch[1]] = 1'b0;
          d.rd = 1'b1;
          d.rd_comp = 1'b0;
          d.addr = q.latch[1] ? evt_flag_pkg::REG_FL_SECOND :
                                evt_flag_pkg::REG_FL_FIRST;
          d.state = evt_flag_pkg::SVC_WAIT;
        end
      end
      evt_flag_pkg::SVC_WAIT: begin
        d.state = evt_flag_pkg::SVC_CAPTURE;
      end
      evt_flag_pkg::SVC_CAPTURE: begin
        if (q.rd_comp) begin
          d.comp[q.cidx] = LINK.rdata;
          d.cidx = q.cidx + 1'b1;
        end else begin
          d.snap[q.line] = LINK.rdata;
          d.cidx = '0;
        end
        d.state = evt_flag_pkg::SVC_SCAN;
      end
      evt_flag_pkg::SVC_SCAN: begin
        if (q.cidx == evt_flag_pkg::CIDX_W'(evt_flag_pkg::COMP_N)) begin
          // Every companion with a flag set in the snapshot is read, so the flags may now be cleared.
          d.wr = 1'b1;
          d.addr = q.line ? evt_flag_pkg::REG_FL_SECOND :
                            evt_flag_pkg::REG_FL_FIRST;
          d.wdata = q.snap[q.line];
          ev[q.line] = 1'b1;
          ev[evt_flag_pkg::HST_RST_SEEN] =
            q.line & q.snap[1][evt_flag_pkg::RST_DONE_BIT];
          d.state = evt_flag_pkg::SVC_IDLE;
        end else begin
          if (evt_flag_pkg::COMP_OF_FIRST[q.cidx] == ~q.line) begin
            need_src = q.snap[q.line];
          end
          if (|(need_src & evt_flag_pkg::COMP_MASK[q.cidx])) begin
            d.rd = 1'b1;
            d.rd_comp = 1'b1;
            d.addr = evt_flag_pkg::REG_COMP_BASE +
                     evt_flag_pkg::ADDR_W'(q.cidx);
            d.state = evt_flag_pkg::SVC_WAIT;
          end else begin
            d.cidx = q.cidx + 1'b1;
          end
        end
      end
    endcase

    // Falling edges set the latch after any clear above.
    d.latch = d.latch | (q.prev_n & ~now_n);

    // Software port.
    d.rdata = '0;
    if (WR_I) begin
      unique case (ADDR_I)
        evt_flag_pkg::HREG_CLEAR: begin
          d.status = q.status & ~WDATA_I[evt_flag_pkg::HST_W-1:0];
        end
        evt_flag_pkg::HREG_ENABLE: begin
          d.enable = WDATA_I[evt_flag_pkg::HST_W-1:0];
        end
        evt_flag_pkg::HREG_DEV_EN_FIRST: begin
          d.pend[0] = 1'b1;
          d.pend_val[0] = WDATA_I;
        end
        evt_flag_pkg::HREG_DEV_EN_SECOND: begin
          d.pend[1] = 1'b1;
          d.pend_val[1] = WDATA_I;
        end
        default: begin
        end
      endcase
    end
    if (RD_I) begin
      unique case (ADDR_I)
        evt_flag_pkg::HREG_STATUS: begin
          d.rdata[evt_flag_pkg::HST_W-1:0] = q.status;
        end
        evt_flag_pkg::HREG_ENABLE: begin
          d.rdata[evt_flag_pkg::HST_W-1:0] = q.enable;
        end
        evt_flag_pkg::HREG_SNAP_FIRST: begin
          d.rdata = q.snap[0];
        end
        evt_flag_pkg::HREG_SNAP_SECOND: begin
          d.rdata = q.snap[1];
        end
        default: begin
          if (ADDR_I >= evt_flag_pkg::HREG_COMP_BASE &&
              sw_comp < evt_flag_pkg::ADDR_W'(evt_flag_pkg::COMP_N)) begin
            d.rdata = q.comp[sw_comp[evt_flag_pkg::CIDX_W-1:0]];
          end
        end
      endcase
    end
    d.status = d.status | ev;
    d.irq = |(d.status & d.enable);
  end

  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      q <= '0;
      q.prev_n <= 2'h3;
    end else begin
      q <= d;
    end
  end

  assign LINK.addr = q.addr;
  assign LINK.wdata = q.wdata;
  assign LINK.wr = q.wr;
  assign LINK.rd = q.rd;
  assign RDATA_O = q.rdata;
  assign IRQ_O = q.irq;

endmodule // evt_flag_host

// >>> evt_link_sva.sv
// Concurrent checks on the link between the flag unit and its host.
`timescale 1ns/100ps
module evt_link_sva (
  input wire logic CORE_CLK_I,
  input wire logic NRST_I,
  input wire logic SOFT_RESET_I,
  input wire logic [evt_flag_pkg::ADDR_W-1:0] addr,
  input wire logic [evt_flag_pkg::WORD_W-1:0] wdata,
  input wire logic [evt_flag_pkg::WORD_W-1:0] rdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic request_line_first_n,
  input wire logic request_line_second_n
);
  localparam logic [3:0] EN1 = evt_flag_pkg::REG_EN_FIRST;
  localparam logic [3:0] EN2 = evt_flag_pkg::REG_EN_SECOND;
  localparam logic [3:0] FL1 = evt_flag_pkg::REG_FL_FIRST;
  localparam logic [3:0] FL2 = evt_flag_pkg::REG_FL_SECOND;
  localparam logic [3:0] CMP1 = evt_flag_pkg::REG_COMP_BASE + 4'h1;
  logic rd_fl2_q;
  logic comp_seen_q;
  logic [evt_flag_pkg::WORD_W-1:0] snap_q;
  logic hit1;
  logic hit2;
  assign hit1 = wr && (addr == EN1 || addr == FL1);
  assign hit2 = wr && (addr == EN2 || addr == FL2);

  // Soft reset is not tracked here; its pulse disables every check.
  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rd_fl2_q <= 1'b0;
      comp_seen_q <= 1'b0;
      snap_q <= '0;
    end else begin
      rd_fl2_q <= rd && addr == FL2;
      if (rd_fl2_q) begin
        snap_q <= rdata;
      end
      if (rd && addr == CMP1) begin
        comp_seen_q <= 1'b1;
      end else if (wr && addr == FL2) begin
        comp_seen_q <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (!NRST_I || SOFT_RESET_I);

  a_boot_line: assert property (
    $rose(NRST_I) |-> ##1 !request_line_second_n)
    else $error("second line not low after reset");
  a_rdata_idle: assert property (
    !$past(rd) |-> rdata == '0)
    else $error("read data outside its cycle");
  a_line1_held: assert property (
    !request_line_first_n && !hit1 |=> !request_line_first_n)
    else $error("first line released without a write");
  a_line2_held: assert property (
    !request_line_second_n && !hit2 |=> !request_line_second_n)
    else $error("second line released without a write");
  a_line1_rise: assert property (
    $rose(request_line_first_n) |-> $past(hit1) || $past(SOFT_RESET_I))
    else $error("first line rose with no cause");
  a_line2_rise: assert property (
    $rose(request_line_second_n) |-> $past(hit2) || $past(SOFT_RESET_I))
    else $error("second line rose with no cause");
  a_comp_first: assert property (
    wr && addr == FL2 && (wdata & evt_flag_pkg::COMP_MASK[1]) != '0
    |-> comp_seen_q)
    else $error("flag cleared before its companion was read");
  a_clear_readback: assert property (
    wr && addr == FL2 |-> wdata == snap_q)
    else $error("write back differs from value read");

  c_line1_fall: cover property ($fell(request_line_first_n));
  c_comp_read: cover property (rd && addr == CMP1);
  c_line2_rise: cover property ($rose(request_line_second_n));
endmodule // evt_link_sva

// >>> dual_line_event_flag_unit_test.sv
// Testbench: flag unit and host joined by the link, driven at both ends.
`timescale 1ns/100ps
module dual_line_event_flag_unit_test;
  localparam int W = evt_flag_pkg::WORD_W;
  localparam int N = 17;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic soft_rst = 1'b0;
  logic [W-1:0] evt1 = '0;
  logic [W-1:0] evt2 = '0;
  logic [evt_flag_pkg::COMP_N-1:0][W-1:0] detail = '0;
  logic [3:0] sw_addr = '0;
  logic [W-1:0] sw_wdata = '0;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic [W-1:0] sw_rdata;
  logic irq;
  int failures = 0;
  int cmp_count = 0;
  int bit_t [N] = '{0, 1, 2, 16, 17, 18, 23, 24, 6, 7, 8, 9, 10, 11, 12, 13,
    18};
  int comp_t [N] = '{0, 0, 0, 1, 1, 1, 2, 3, 4, 4, 4, 4, 4, 4, 4, 4, 4};

  always #2.5 clk = ~clk;
  evt_link_if i_evt_link_if ();
  evt_flag_dev i_evt_flag_dev (.CORE_CLK_I(clk), .NRST_I(nrst),
    .SOFT_RESET_I(soft_rst), .EVT_FIRST_I(evt1), .EVT_SECOND_I(evt2),
    .PHASE_DETAIL_I(detail), .LINK(i_evt_link_if));
  evt_flag_host i_evt_flag_host (.CORE_CLK_I(clk), .NRST_I(nrst),
    .ADDR_I(sw_addr), .WDATA_I(sw_wdata), .WR_I(sw_wr), .RD_I(sw_rd),
    .RDATA_O(sw_rdata), .IRQ_O(irq), .LINK(i_evt_link_if));
  evt_link_sva i_evt_link_sva (.CORE_CLK_I(clk), .NRST_I(nrst),
    .SOFT_RESET_I(soft_rst), .addr(i_evt_link_if.addr),
    .wdata(i_evt_link_if.wdata), .rdata(i_evt_link_if.rdata),
    .wr(i_evt_link_if.wr), .rd(i_evt_link_if.rd),
    .request_line_first_n(i_evt_link_if.request_line_first_n),
    .request_line_second_n(i_evt_link_if.request_line_second_n));

  task automatic check(string what, logic [W-1:0] exp, logic [W-1:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic sw_write(logic [3:0] a, logic [W-1:0] d);
    @(posedge clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clk);
    sw_wr <= 1'b0;
  endtask

  task automatic sw_read(logic [3:0] a, logic [W-1:0] exp, string what);
    @(posedge clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk);
    sw_rd <= 1'b0;
    #1;
    check(what, exp, sw_rdata);
  endtask

  // The interrupt is a registered level, so look two edges after the cause.
  task automatic irq_is(logic exp, string what);
    repeat (2) @(posedge clk);
    #1;
    check(what, {31'h0, exp}, {31'h0, irq});
  endtask

  task automatic wait_irq();
    for (int n = 0; n < 200 && irq !== 1'b1; n++) @(posedge clk);
    #1;
    check("irq raised", 32'h1, {31'h0, irq});
  endtask

  task automatic wrap_up();
    $display("Compares %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    #100000;
    failures++;
    wrap_up();
  end

  initial begin
    logic [W-1:0] m;
    logic [W-1:0] v;
    logic first;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    sw_write(evt_flag_pkg::HREG_ENABLE, 32'h7);
    wait_irq();
    sw_read(evt_flag_pkg::HREG_STATUS, 32'h6, "boot status");
    sw_read(evt_flag_pkg::HREG_SNAP_SECOND, 32'h8000, "boot flags");
    sw_read(4'hf, 32'h0, "unmapped");
    sw_read(evt_flag_pkg::HREG_CLEAR, 32'h0, "clear reads zero");
    irq_is(1'b1, "irq set");
    sw_write(evt_flag_pkg::HREG_ENABLE, 32'h0);
    irq_is(1'b0, "irq masked");
    sw_write(evt_flag_pkg::HREG_CLEAR, 32'h7);
    sw_write(evt_flag_pkg::HREG_ENABLE, 32'h7);
    irq_is(1'b0, "irq cleared");
    $display("Test boot done");
    // Every event but reset-finished while both device enable words are still at their reset value.
    @(posedge clk);
    detail[4] <= 32'h0000_0abc;
    detail[1] <= 32'h0000_0123;
    evt1 <= 32'hffff_ffff;
    evt2 <= 32'hffff_7fff;
    @(posedge clk);
    evt1 <= '0;
    evt2 <= '0;
    repeat (30) @(posedge clk);
    sw_read(evt_flag_pkg::HREG_STATUS, 32'h0, "masked status");
    sw_write(evt_flag_pkg::HREG_DEV_EN_FIRST, 32'h40);
    wait_irq();
    sw_read(evt_flag_pkg::HREG_SNAP_FIRST, 32'hffff_ffff, "sticky 1");
    sw_read(evt_flag_pkg::HREG_COMP_BASE + 4'h4, 32'habc, "sign");
    sw_write(evt_flag_pkg::HREG_CLEAR, 32'h7);
    sw_write(evt_flag_pkg::HREG_DEV_EN_SECOND, 32'h1_0000);
    wait_irq();
    sw_read(evt_flag_pkg::HREG_SNAP_SECOND, 32'hffff_7fff, "sticky 2");
    sw_read(evt_flag_pkg::HREG_COMP_BASE + 4'h1, 32'h123, "cond");
    $display("Test masked events done");
    sw_write(evt_flag_pkg::HREG_DEV_EN_SECOND, 32'h0);
    sw_write(evt_flag_pkg::HREG_CLEAR, 32'h7);
    @(posedge clk);
    soft_rst <= 1'b1;
    @(posedge clk);
    soft_rst <= 1'b0;
    wait_irq();
    sw_read(evt_flag_pkg::HREG_STATUS, 32'h6, "soft reset status");
    $display("Test soft reset done");
    for (int i = 0; i < N; i++) begin
      first = (comp_t[i] == 4);
      m = 32'h1 << bit_t[i];
      v = 32'h5a00_0003 | (32'(i) << 8);
      sw_write(evt_flag_pkg::HREG_CLEAR, 32'h7);
      sw_write(first ? evt_flag_pkg::HREG_DEV_EN_FIRST :
        evt_flag_pkg::HREG_DEV_EN_SECOND, m);
      @(posedge clk);
      detail[comp_t[i]] <= v;
      if (first) evt1 <= m;
      else evt2 <= m;
      @(posedge clk);
      evt1 <= '0;
      evt2 <= '0;
      wait_irq();
      sw_read(first ? evt_flag_pkg::HREG_SNAP_FIRST :
        evt_flag_pkg::HREG_SNAP_SECOND, m, "flags");
      sw_read(evt_flag_pkg::HREG_COMP_BASE + 4'(comp_t[i]), v,
        "companion");
      $display("Test event bit %0d done", bit_t[i]);
    end
    // Hold an event over the clearing edge of the host's write-back. The
    // flag must survive, so re-enabling its bit calls the host again;
    // a lost flag leaves the interrupt low and the check trips.
    m = 32'h1 << 17;
    sw_write(evt_flag_pkg::HREG_CLEAR, 32'h7);
    sw_write(evt_flag_pkg::HREG_DEV_EN_SECOND, m);
    @(posedge clk);
    evt2 <= m;
    do @(posedge clk);
    while (!(i_evt_link_if.wr &&
      i_evt_link_if.addr == evt_flag_pkg::REG_FL_SECOND));
    evt2 <= '0;
    sw_write(evt_flag_pkg::HREG_CLEAR, 32'h7);
    sw_write(evt_flag_pkg::HREG_DEV_EN_SECOND, 32'h0);
    sw_write(evt_flag_pkg::HREG_DEV_EN_SECOND, m);
    wait_irq();
    sw_read(evt_flag_pkg::HREG_SNAP_SECOND, m, "set wins");
    $display("Test set over clear done");
    wrap_up();
  end
endmodule // dual_line_event_flag_unit_test
